/* File: common/ref_capture_pkg.sv */
// Constants and carrier types for the timing-reference capture block.
// Assumes a 32-bit APB slave with word-aligned registers.
package ref_capture_pkg;

  localparam int TAPS = 24;
  localparam int SEL_TAPS = 16;
  localparam int SEL_W = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_POS_LO = 10'h02c;
  localparam logic [9:0] IDX_POS_MID = 10'h02d;
  localparam logic [9:0] IDX_POS_HI = 10'h02e;
  localparam logic [9:0] IDX_CTRL = 10'h030;
  localparam logic [9:0] IDX_PERIOD = 10'h031;
  localparam logic [9:0] IDX_COUNT = 10'h032;

  localparam logic [ADDR_W-1:0] A_POS_LO = {IDX_POS_LO, 2'b00};
  localparam logic [ADDR_W-1:0] A_POS_MID = {IDX_POS_MID, 2'b00};
  localparam logic [ADDR_W-1:0] A_POS_HI = {IDX_POS_HI, 2'b00};
  localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_PERIOD = {IDX_PERIOD, 2'b00};
  localparam logic [ADDR_W-1:0] A_COUNT = {IDX_COUNT, 2'b00};

  // Control register layout, low bits of the word
  typedef struct packed {
    logic link_format_setting;
    logic fine_delay_step_enable;
    logic [SEL_W-1:0] reference_tap_select;
  } ref_ctrl_s;

  localparam int CTRL_W = $bits(ref_ctrl_s);
  localparam ref_ctrl_s CTRL_RST = '{1'b0, 1'b1, 4'h0};
  localparam logic [TAPS-1:0] POS_RST = 24'hff_ffff;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0020;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

endpackage

/* File: design/ref_capture.sv */
// Timing-reference window capture: phase detector, tap select,
// frame counter reset, APB register slave.
// Assumes the 24 delayed samples of the reference arrive synchronous
// to pclk from analog delay lines, one coarse and one fine.
//
// Behaviour
// (RULE1) Reference may be single pulse or periodic
// (RULE2) 8B/10B period: multiframe rate or fraction
// (RULE3) 64B/66B period: extended multiblock rate divided
// (RULE4) Latch reference at a selectable delayed tap
// (RULE5) Record reference position in phase status
// (RULE6) Status one means risky, zero means valid
// (RULE7) Status bits 0 and 23 always one
// (RULE8) 24 status bits, select reaches first 16
// (RULE9) Select value is binary status bit index
// (RULE10) Step coarse when control 0, fine when 1
// (RULE11) Software should prefer fine steps
// (RULE12) Software picks middle, prefers lower values
// (RULE13) Apply clocks, read status, then select
// (RULE14) Store optimal select, reapply at power-up
// (RULE15) Captured reference resets frame counter
// (RULE16) Four-bit select; status refreshed continuously; here only on cycles with an edge, held otherwise
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module ref_capture #(
  parameter int TAPS = ref_capture_pkg::TAPS,
  parameter int SEL_TAPS = ref_capture_pkg::SEL_TAPS,
  parameter int CNT_W = ref_capture_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ref_capture_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TAPS-1:0] ref_taps_coarse,
  input wire logic [TAPS-1:0] ref_taps_fine,
  output logic ref_captured,
  output logic [CNT_W-1:0] frame_count,
  output logic lmfc_boundary,
  output logic lemc_boundary
);

  // ==========================================================
  // Elaboration checks
  if (TAPS != 24 || SEL_TAPS != 16 || CNT_W < 2 || CNT_W > 32) begin : g_bad
    $error("ref_capture: unsupported parameter values");
  end

  // ==========================================================
  // APB decode
  wire logic setup_ph;
  wire logic wr_acc;
  wire logic hit_lo;
  wire logic hit_mid;
  wire logic hit_hi;
  wire logic hit_ctrl;
  wire logic hit_period;
  wire logic hit_count;
  wire logic hit_any;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit_lo = paddr == ref_capture_pkg::A_POS_LO;
  assign hit_mid = paddr == ref_capture_pkg::A_POS_MID;
  assign hit_hi = paddr == ref_capture_pkg::A_POS_HI;
  assign hit_ctrl = paddr == ref_capture_pkg::A_CTRL;
  assign hit_period = paddr == ref_capture_pkg::A_PERIOD;
  assign hit_count = paddr == ref_capture_pkg::A_COUNT;
  assign hit_any = hit_lo | hit_mid | hit_hi | hit_ctrl | hit_period | hit_count;

  // Zero wait states; unmapped addresses error in the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ==========================================================
  // Software registers
  ref_capture_pkg::ref_ctrl_s ctrl_q;
  ref_capture_pkg::ref_ctrl_s ctrl_d;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] period_d;

  // The select field is four bits wide, so only taps 0..15 are reachable
  assign ctrl_d = (wr_acc && hit_ctrl)
    ? ref_capture_pkg::ref_ctrl_s'(pwdata[ref_capture_pkg::CTRL_W-1:0])
    : ctrl_q; // [RULE8] [RULE16]
  assign period_d = (wr_acc && hit_period) ? pwdata[CNT_W-1:0] : period_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ref_capture_pkg::CTRL_RST;
      period_q <= ref_capture_pkg::PERIOD_RST;
    end else begin
      ctrl_q <= ctrl_d;
      period_q <= period_d;
    end
  end

  // ==========================================================
  // Tap set selection and phase detector
  wire logic [TAPS-1:0] taps_sel;
  wire logic [TAPS-1:0] pos_raw;
  wire logic edge_seen;
  logic [TAPS-1:0] pos_q;
  logic [TAPS-1:0] pos_d;

  assign taps_sel = ctrl_q.fine_delay_step_enable
    ? ref_taps_fine : ref_taps_coarse; // [RULE10]

  // A tap next to a level change sits on the reference edge and may
  // violate setup or hold; end taps lack a neighbour so stay flagged
  assign pos_raw[0] = 1'b1; // [RULE7]
  assign pos_raw[TAPS-1] = 1'b1; // [RULE7]
  for (genvar i = 1; i < TAPS - 1; i++) begin : g_pos
    assign pos_raw[i] = (taps_sel[i] != taps_sel[i-1])
      || (taps_sel[i] != taps_sel[i+1]); // [RULE5] [RULE6]
  end

  // Only a cycle holding an edge tells where the reference lies, so the
  // status refreshes on every such cycle and holds otherwise
  assign edge_seen = (|taps_sel) && !(&taps_sel);
  assign pos_d = edge_seen ? pos_raw : pos_q; // [RULE16] [RULE1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= ref_capture_pkg::POS_RST;
    end else begin
      pos_q <= pos_d;
    end
  end

  // ==========================================================
  // Capture at the selected delay and frame counter
  wire logic sample_d;
  wire logic capture_edge;
  wire logic wrap;
  logic sample_q;
  logic prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic boundary_q;

  assign sample_d = taps_sel[ctrl_q.reference_tap_select]; // [RULE4] [RULE9]
  // Rising edge only: a periodic reference re-aligns each period
  assign capture_edge = sample_q && !prev_q; // [RULE1]
  // A period of zero or one behaves as one; without the first term a zero
  // period would underflow and run the counter over its full range
  assign wrap = (period_q <= CNT_W'(1))
    || (cnt_q >= period_q - CNT_W'(1));
  assign cnt_d = (capture_edge || wrap)
    ? '0 : cnt_q + CNT_W'(1); // [RULE15]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= 1'b0;
      prev_q <= 1'b0;
      cnt_q <= '0;
      boundary_q <= 1'b0;
    end else begin
      sample_q <= sample_d;
      prev_q <= sample_q;
      cnt_q <= cnt_d;
      boundary_q <= cnt_d == '0;
    end
  end

  assign ref_captured = sample_q;
  assign frame_count = cnt_q;
  assign lmfc_boundary = boundary_q && !ctrl_q.link_format_setting; // [RULE15]
  assign lemc_boundary = boundary_q && ctrl_q.link_format_setting; // [RULE15]

  // ==========================================================
  // Read data, registered in the setup phase
  logic [31:0] rdata_mux;
  logic [31:0] prdata_q;

  always_comb begin
    rdata_mux = ref_capture_pkg::ZERO32;
    if (hit_lo) begin
      rdata_mux[7:0] = pos_q[7:0]; // [RULE5]
    end
    if (hit_mid) begin
      rdata_mux[7:0] = pos_q[15:8];
    end
    if (hit_hi) begin
      rdata_mux[7:0] = pos_q[23:16]; // [RULE8]
    end
    if (hit_ctrl) begin
      rdata_mux[ref_capture_pkg::CTRL_W-1:0] = ctrl_q;
    end
    if (hit_period) begin
      rdata_mux[CNT_W-1:0] = period_q;
    end
    if (hit_count) begin
      rdata_mux[CNT_W-1:0] = cnt_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= ref_capture_pkg::ZERO32;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rdata_mux;
    end
  end

  assign prdata = prdata_q;

  // ==========================================================
  // Assertions
  property p_tap_capture;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> sample_q == ($past(ctrl_q.fine_delay_step_enable)
      ? $past(ref_taps_fine[ctrl_q.reference_tap_select])
      : $past(ref_taps_coarse[ctrl_q.reference_tap_select]));
  endproperty
  a_tap_capture: assert property (p_tap_capture) // [RULE4] [RULE9]
    else $error("sample does not follow selected tap");

  property p_step_size;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q.fine_delay_step_enable |-> taps_sel == ref_taps_coarse;
  endproperty
  a_step_size: assert property (p_step_size) // [RULE10]
    else $error("coarse taps not used when fine steps off");

  property p_end_bits;
    @(posedge pclk) disable iff (!presetn)
    pos_q[0] && pos_q[TAPS-1];
  endproperty
  a_end_bits: assert property (p_end_bits) // [RULE7]
    else $error("status end bits not set");

  property p_risk_bit;
    @(posedge pclk) disable iff (!presetn)
    edge_seen |=> pos_q[5] == ($past(taps_sel[5]) != $past(taps_sel[4])
      || $past(taps_sel[5]) != $past(taps_sel[6]));
  endproperty
  a_risk_bit: assert property (p_risk_bit) // [RULE6]
    else $error("status bit does not mark edge neighbourhood");

  property p_hold_status;
    @(posedge pclk) disable iff (!presetn)
    !edge_seen |=> $stable(pos_q);
  endproperty
  a_hold_status: assert property (p_hold_status) // [RULE16]
    else $error("status changed without an edge");

  property p_read_low;
    @(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_lo |=> prdata == {24'h00_0000, $past(pos_q[7:0])};
  endproperty
  a_read_low: assert property (p_read_low) // [RULE5]
    else $error("low status read wrong");

  property p_read_high;
    @(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_hi |=> prdata[7:0] == $past(pos_q[23:16]);
  endproperty
  a_read_high: assert property (p_read_high) // [RULE8]
    else $error("high status read wrong");

  property p_counter_reset;
    @(posedge pclk) disable iff (!presetn)
    capture_edge && period_q > 16'h0003 |=> cnt_q == '0 ##1 cnt_q == CNT_W'(1);
  endproperty
  a_counter_reset: assert property (p_counter_reset) // [RULE15]
    else $error("frame counter not reset by captured reference");

  property p_boundary;
    @(posedge pclk) disable iff (!presetn)
    cnt_d == '0 |=> lmfc_boundary != lemc_boundary;
  endproperty
  a_boundary: assert property (p_boundary) // [RULE15]
    else $error("boundary pulse missing at count zero");

  property p_select_write;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && hit_ctrl |=> ctrl_q.reference_tap_select
      == $past(pwdata[ref_capture_pkg::SEL_W-1:0]);
  endproperty
  a_select_write: assert property (p_select_write) // [RULE8] [RULE16]
    else $error("tap select not taken from low write bits");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && !capture_edge && !wrap |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step) // [RULE15]
    else $error("frame counter did not advance");

  c_lemc: cover property (@(posedge pclk) disable iff (!presetn) lemc_boundary);
  c_capture: cover property (@(posedge pclk) disable iff (!presetn) capture_edge);
  c_fine_edge: cover property (@(posedge pclk) disable iff (!presetn)
    edge_seen && ctrl_q.fine_delay_step_enable);
  c_sel15: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.reference_tap_select == 4'hf && capture_edge);
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap && !capture_edge);

endmodule

`default_nettype wire

/* File: bench/ref_clockgen_model.sv */
// Partner model: clock generator that drives the 24 delayed reference samples.
// Assumes pclk is the device clock; the bench requests pulses or a periodic train.
`timescale 1ns/100ps
`default_nettype none
module ref_clockgen_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic per_en,
  input wire logic [4:0] pos_c,
  input wire logic [4:0] pos_f,
  output logic [23:0] ref_taps_coarse,
  output logic [23:0] ref_taps_fine
);
  logic [4:0] cnt_q;
  logic lvl_q;
  logic go;
  logic lvl_d;
  // ==========================================================
  // Pulse or 32-cycle train, twice the 16-cycle frame in use
  assign go = fire | (per_en & (cnt_q == 5'h0));
  assign lvl_d = go | ((cnt_q != 5'h0) & (cnt_q < 5'h4));
  // Taps below the edge position still see the old level
  function automatic logic [23:0] mix(input logic o, input logic n, input logic [4:0] p);
    logic [23:0] m;
    m = ~((24'h00_0001 << p) - 24'h00_0001);
    return ({24{n}} & m) | ({24{o}} & ~m);
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h0;
      lvl_q <= 1'b0;
      ref_taps_coarse <= 24'h00_0000;
      ref_taps_fine <= 24'h00_0000;
    end else begin
      cnt_q <= go ? 5'h1 : ((cnt_q == 5'h0) ? 5'h0 : cnt_q + 5'h1);
      lvl_q <= lvl_d;
      ref_taps_coarse <= mix(lvl_q, lvl_d, pos_c);
      ref_taps_fine <= mix(lvl_q, lvl_d, pos_f);
    end
  end
endmodule
`default_nettype wire

/* File: bench/sysref_window_capture_tb.sv */
// Self-checking bench for the reference capture block.
// Assumes the clock generator model on the tap inputs and an APB master here.
`timescale 1ns/100ps
`default_nettype none
module sysref_window_capture_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, per_en;
  logic ref_captured, lmfc_boundary, lemc_boundary;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic [31:0] cyc = 32'h0000_0000;
  logic [23:0] taps_c, taps_f;
  logic [15:0] frame_count;
  logic [4:0] pos_c, pos_f;
  logic [33:0] note_q[$];
  logic [31:0] cap_q[$], bnd_q[$];
  logic cap_prev = 1'b0;
  int n_mismatch, n_compared;
  ref_capture DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_taps_coarse(taps_c), .ref_taps_fine(taps_f),
    .ref_captured(ref_captured), .frame_count(frame_count),
    .lmfc_boundary(lmfc_boundary), .lemc_boundary(lemc_boundary));
  ref_clockgen_model gen (.pclk(pclk), .presetn(presetn), .fire(fire), .per_en(per_en),
    .pos_c(pos_c), .pos_f(pos_f), .ref_taps_coarse(taps_c), .ref_taps_fine(taps_f));
  // ==========================================================
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask
  task automatic chk_cap(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask
  task automatic chk_bnd(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Drivers: note the expected result, then make the request
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    note_q.push_back({wr, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic launch(input logic per, input logic [3:0] tap, input logic [4:0] p,
                        input logic fmt);
    logic [31:0] r, e;
    @(negedge pclk);
    // A tap below the edge only sees the level one cycle later
    r = cyc + ((tap >= p) ? 32'h0000_0003 : 32'h0000_0004);
    // The train still fires at the fourth period start before it is stopped
    for (int j = 0; j < (per ? 4 : 1); j++) cap_q.push_back(r + 32'(32 * j));
    // The counter clears one edge after the capture, the boundary shows then
    for (int j = 0; j < (per ? 6 : 1); j++) begin
      e = r + 32'(1 + 16 * j);
      bnd_q.push_back({e[13:0], fmt, ~fmt, 16'h0000});
    end
    @(posedge pclk);
    if (per) per_en <= 1'b1;
    else fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (per ? 100 : 12) @(posedge pclk);
    per_en <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic read_status(input logic [4:0] p);
    logic [23:0] x;
    x = 24'h80_0001 | (24'h00_0001 << p) | (24'h00_0001 << (p - 5'h1));
    for (int i = 0; i < 3; i++)
      apb(1'b0, ref_capture_pkg::A_POS_LO + 12'(4 * i), 0, 32'(x[8*i+:8]), 1'b0);
  endtask
  // ==========================================================
  // Monitors: take the oldest note whenever a result shows
  always @(posedge pclk) begin
    cyc <= cyc + 32'h0000_0001;
    if (cyc == 32'h0000_1388) begin
      n_mismatch++;
      test_done();
    end
    if ((psel & penable & pready) === 1'b1 && note_q.size() > 0) begin
      chk_bus("pslverr", {31'h0, note_q[0][32]}, {31'h0, pslverr});
      if (!note_q[0][33]) chk_bus("prdata", note_q[0][31:0], prdata);
      void'(note_q.pop_front());
    end
  end
  always @(negedge pclk) begin
    if (ref_captured === 1'b1 && cap_prev === 1'b0 && cap_q.size() > 0)
      chk_cap("capture_cycle", cap_q.pop_front(), cyc);
    cap_prev = ref_captured;
    if ((lmfc_boundary | lemc_boundary) === 1'b1 && bnd_q.size() > 0)
      chk_bnd("boundary", bnd_q.pop_front(),
        {cyc[13:0], lemc_boundary, lmfc_boundary, frame_count});
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [3:0] tap;
    logic fine, fmt;
    {presetn, psel, penable, pwrite, fire, per_en} = 6'h00;
    {paddr, pwdata, pos_c, pos_f} = '0;
    s = $urandom(32'h00bf_f6d0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++)
      apb(1'b0, ref_capture_pkg::A_POS_LO + 12'(4 * i), 0, 32'h0000_00ff, 1'b0);
    apb(1'b0, ref_capture_pkg::A_CTRL, 0, 32'h0000_0010, 1'b0);
    apb(1'b0, 12'hffc, 0, 0, 1'b1);
    apb(1'b1, ref_capture_pkg::A_POS_LO, 32'h0000_0000, 0, 1'b0);
    apb(1'b0, ref_capture_pkg::A_POS_LO, 0, 32'h0000_00ff, 1'b0);
    apb(1'b1, ref_capture_pkg::A_PERIOD, 32'h0000_4000, 0, 1'b0);
    for (int k = 0; k < 9; k++) begin
      fine = k[0];
      fmt = (k < 8) ? k[1] : 1'b0;
      tap = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom_range(15, 0));
      pos_c <= 5'($urandom_range(22, 1));
      pos_f <= 5'($urandom_range(22, 1));
      // Shorten the frame first, so its first wrap is over before a boundary is noted
      if (k == 8) begin
        apb(1'b1, ref_capture_pkg::A_PERIOD, 32'h0000_0010, 0, 1'b0);
        apb(1'b0, ref_capture_pkg::A_PERIOD, 0, 32'h0000_0010, 1'b0);
      end
      s = {$urandom} & 32'hffff_ffc0;
      apb(1'b1, ref_capture_pkg::A_CTRL, s | {26'h0, fmt, fine, tap}, 0, 1'b0);
      apb(1'b0, ref_capture_pkg::A_CTRL, 0, {26'h0, fmt, fine, tap}, 1'b0);
      launch(k == 8, tap, fine ? pos_f : pos_c, fmt);
      read_status(fine ? pos_f : pos_c);
    end
    // Power-up again: reapply a select value found once from the status
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ref_capture_pkg::A_COUNT, 0, 32'h0000_0001, 1'b0);
    apb(1'b1, ref_capture_pkg::A_PERIOD, 32'h0000_4000, 0, 1'b0);
    apb(1'b0, ref_capture_pkg::A_CTRL, 0, 32'h0000_0010, 1'b0);
    pos_f <= 5'h14;
    launch(1'b0, 4'h0, 5'h14, 1'b0);
    read_status(5'h14);
    // Flags at 0 and 19..20: midway is 9 or 10, the lower drifts less
    apb(1'b1, ref_capture_pkg::A_CTRL, 32'h0000_0019, 0, 1'b0);
    apb(1'b0, ref_capture_pkg::A_CTRL, 0, 32'h0000_0019, 1'b0);
    launch(1'b0, 4'h9, 5'h14, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
